//--- core/i2c_hub_pkg.sv
package i2c_hub_pkg;
  // register offsets on the local target
  localparam logic [7:0] OFS_PRIMARY = 8'h00;
  localparam logic [7:0] OFS_PORT_SEL = 8'h4c;
  localparam logic [7:0] OFS_LOCK_STAT = 8'h4d;
  localparam logic [7:0] OFS_CC_CONFIG = 8'h58;
  localparam logic [7:0] OFS_PORT0_ADDR = 8'hf8;
  localparam logic [7:0] OFS_PORT1_ADDR = 8'hf9;
  // reset values
  localparam logic [7:0] PORT_SEL_RST = 8'h01;
  localparam logic [7:0] ADDR_REG_RST = 8'h00;
  localparam logic [7:0] CC_CONFIG_RST = 8'h00;
  // port select fields: read page bit, write enable mask
  localparam int PSEL_RD_BIT = 4;
  localparam int PSEL_WR_LSB = 0;
  // backchannel_rate_field in control_channel_config
  localparam int RATE_LSB = 0;
  localparam int RATE_W = 3;
  localparam logic [2:0] RATE_SLOW = 3'h0;
  localparam logic [2:0] RATE_FAST = 3'h6;
  // strap decode
  localparam logic [6:0] STRAP_BASE = 7'h30;
  localparam logic [6:0] STRAP_TOP = 7'h3d;
  localparam logic [2:0] STRAP_TOP_LEVEL = 3'h7;
  // timing
  localparam int CLK_HZ = 100_000_000;
  localparam int STRAP_WAIT_MS = 1;
  localparam int STRAP_WAIT_CYC_DEF = STRAP_WAIT_MS * (CLK_HZ / 1000);
  localparam int FAST_KBPS = 50_000;
  localparam int SLOW_KBPS = 2_500;
  localparam int SLOW_DIV = FAST_KBPS / SLOW_KBPS;
  // back channel frame
  localparam logic [3:0] FRAME_HDR = 4'ha;
  localparam logic [3:0] CAPS_DEF = 4'h3;
  localparam int FRAME_W = 12;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // i2c pins as seen by the target
  typedef struct packed {
    logic scl;
    logic sda;
  } i2c_pins_t;

  // target state machine, one-hot
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_AACK = 7'h04,
    ST_WDAT = 7'h08,
    ST_WACK = 7'h10,
    ST_RDAT = 7'h20,
    ST_RACK = 7'h40
  } tgt_state_t;

  // strap level to 7-bit address
  function automatic logic [6:0] strap_addr(input logic [2:0] lvl);
    if (lvl == STRAP_TOP_LEVEL) begin
      strap_addr = STRAP_TOP;
    end else begin
      strap_addr = STRAP_BASE + {3'h0, lvl, 1'b0};
    end
  endfunction

  // address register hit; zero means disabled
  function automatic logic addr_hit(input logic [6:0] a, input logic [7:0] r);
    addr_hit = (r != 8'h00) && (r[7:1] == a);
  endfunction
endpackage

//--- core/i2c_hub_target.sv
`timescale 1ns/1ns
// Behaviour
// - mode strap default, per-port rate override
// - fast and slow back-channel rates
// - back channel carries gpio and capabilities
// - wait fixed delay, then sample strap
// - primary address held at offset zero
// - two per-port direct addresses, no paging
// - direct addresses reach shared registers too
// - eight strap levels map to addresses
// - works at standard, fast, fast-plus
// - never stretch scl on local access
// - ack on match, release on mismatch
// - ack every written data byte
// - start opens, stop closes each transaction
// - drive low or release, never high
// - port select pages primary accesses
module i2c_hub_target
  import i2c_hub_pkg::*;
#(
  parameter int STRAP_WAIT_CYC = i2c_hub_pkg::STRAP_WAIT_CYC_DEF
) (
  // system
  input wire logic CLK,
  input wire logic RSTN,
  // straps, power-down and port lock status
  input wire logic POWER_DOWN_RELEASE_PIN,
  input wire logic [2:0] ADDRESS_STRAP_PIN,
  input wire logic MODE_STRAP_PIN,
  input wire logic [1:0] PORT_LOCK,
  // i2c target pins
  input wire i2c_hub_pkg::i2c_pins_t I2C_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // back channel link
  input wire logic LINK_CLK,
  input wire logic [3:0] GPIO_IN,
  output logic [1:0] BACKCHANNEL_TX
);
  import i2c_hub_pkg::*;

  localparam int WAIT_W = $clog2(STRAP_WAIT_CYC + 1);

  // pin synchronisers, first stage feeds only the second
  logic [8:0] pin_s1_reg;
  logic [8:0] pin_s2_reg;
  logic scl_d_reg; // delayed scl for edge detect
  logic sda_d_reg; // delayed sda for edge detect
  logic pwr_on_s, mode_s, scl_s, sda_s;
  logic [2:0] strap_s;
  logic [1:0] lock_s;
  logic rst_any; // reset or power-down held low
  logic scl_rise, scl_fall, start_det, stop_det;

  // straps and power-up
  logic [WAIT_W-1:0] wait_cnt_reg;
  logic addr_valid_reg; // bus ignored until strap taken

  // register file
  logic [7:0] prim_reg;
  logic [7:0] port_sel_reg;
  logic [1:0][7:0] cfg_reg;
  logic [1:0][7:0] port_addr_reg;
  logic [7:0] rd_data;

  // target engine
  tgt_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] ptr_reg;
  logic wr_first_reg; // first written byte is the pointer
  logic direct_reg; // matched a per-port address
  logic page_reg; // port of a direct match
  logic sda_oe_reg;
  logic sda_out_reg;
  logic hit_p, hit_0, hit_1, any_hit;
  logic rd_page;
  logic [1:0] wr_mask;
  logic wr_en;

  // crossing toward the link domain
  logic rst_flag_reg;
  logic [1:0] fast_cc_reg;

  // pin synchronisers
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      pin_s1_reg <= 9'h003;
      pin_s2_reg <= 9'h003;
    end else begin
      pin_s1_reg <= {POWER_DOWN_RELEASE_PIN, MODE_STRAP_PIN, ADDRESS_STRAP_PIN, PORT_LOCK,
                     I2C_IN.scl, I2C_IN.sda};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  assign pwr_on_s = pin_s2_reg[8];
  assign mode_s = pin_s2_reg[7];
  assign strap_s = pin_s2_reg[6:4];
  assign lock_s = pin_s2_reg[3:2];
  assign scl_s = pin_s2_reg[1];
  assign sda_s = pin_s2_reg[0];
  assign rst_any = !RSTN || !pwr_on_s;

  // delayed copies for edge detection
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // bus conditions; pins sampled at 100 MHz, ample for 1 MHz scl
  assign scl_rise = scl_s && !scl_d_reg;
  assign scl_fall = !scl_s && scl_d_reg;
  assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign stop_det = scl_s && scl_d_reg && !sda_d_reg && sda_s;

  // power-down release delay before strap sampling
  always_ff @(posedge CLK) begin
    if (rst_any) begin
      wait_cnt_reg <= '0;
      addr_valid_reg <= 1'b0;
    end else if (!addr_valid_reg) begin
      wait_cnt_reg <= wait_cnt_reg + 1'b1;
      if (wait_cnt_reg == WAIT_W'(STRAP_WAIT_CYC - 1)) begin
        addr_valid_reg <= 1'b1;
      end
    end
  end

  // address compare against all three at once
  assign hit_p = addr_hit(shift_reg[7:1], prim_reg);
  assign hit_0 = addr_hit(shift_reg[7:1], port_addr_reg[0]);
  assign hit_1 = addr_hit(shift_reg[7:1], port_addr_reg[1]);
  assign any_hit = hit_p || hit_0 || hit_1;

  // page routing: direct hit uses its port, else port select
  assign rd_page = direct_reg ? page_reg : port_sel_reg[PSEL_RD_BIT];
  assign wr_mask = direct_reg ? (page_reg ? 2'h2 : 2'h1)
                              : port_sel_reg[PSEL_WR_LSB +: 2];
  assign wr_en = (state_reg == ST_WDAT) && scl_fall && (bit_cnt_reg == BITS_PER_BYTE)
                 && !wr_first_reg;

  // register file writes; strap capture loads the defaults
  always_ff @(posedge CLK) begin
    if (rst_any) begin
      prim_reg <= ADDR_REG_RST;
      port_sel_reg <= PORT_SEL_RST;
      cfg_reg <= {2{CC_CONFIG_RST}};
      port_addr_reg <= {2{ADDR_REG_RST}};
    end else if (!addr_valid_reg) begin
      if (wait_cnt_reg == WAIT_W'(STRAP_WAIT_CYC - 1)) begin
        prim_reg <= {strap_addr(strap_s), 1'b0};
        for (int i = 0; i < 2; i++) begin
          cfg_reg[i][RATE_LSB +: RATE_W] <= mode_s ? RATE_FAST : RATE_SLOW;
        end
      end
    end else if (wr_en) begin
      // shared registers answer on any matched address
      case (ptr_reg)
        OFS_PRIMARY: prim_reg <= shift_reg;
        OFS_PORT_SEL: port_sel_reg <= shift_reg;
        OFS_PORT0_ADDR: port_addr_reg[0] <= shift_reg;
        OFS_PORT1_ADDR: port_addr_reg[1] <= shift_reg;
        OFS_CC_CONFIG: begin
          // per-port rate override through the paged copy
          for (int i = 0; i < 2; i++) begin
            if (wr_mask[i]) begin
              cfg_reg[i] <= shift_reg;
            end
          end
        end
        default: begin
          // unmapped or read-only offsets drop the write
        end
      endcase
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    case (ptr_reg)
      OFS_PRIMARY: rd_data = prim_reg;
      OFS_PORT_SEL: rd_data = port_sel_reg;
      OFS_LOCK_STAT: rd_data = {7'h00, lock_s[rd_page]}; // lets host check lock
      OFS_CC_CONFIG: rd_data = cfg_reg[rd_page];
      OFS_PORT0_ADDR: rd_data = port_addr_reg[0];
      OFS_PORT1_ADDR: rd_data = port_addr_reg[1];
      default: rd_data = 8'h00;
    endcase
  end

  // target engine; scl is input only, so it is never stretched
  always_ff @(posedge CLK) begin
    if (rst_any || !addr_valid_reg) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      wr_first_reg <= 1'b0;
      direct_reg <= 1'b0;
      page_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (stop_det) begin
      // stop ends any transfer and frees the line
      state_reg <= ST_IDLE;
      sda_oe_reg <= 1'b0;
    end else if (start_det) begin
      // start or repeated start opens a new address phase
      state_reg <= ST_ADDR;
      bit_cnt_reg <= 4'h0;
      wr_first_reg <= 1'b1;
      sda_oe_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          // wait for a start; unaddressed traffic is ignored
        end
        ST_ADDR, ST_WDAT: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == BITS_PER_BYTE) begin
            bit_cnt_reg <= 4'h0;
            if (state_reg == ST_ADDR) begin
              if (any_hit) begin
                sda_oe_reg <= 1'b1;
                state_reg <= ST_AACK;
                direct_reg <= !hit_p && (hit_0 || hit_1);
                page_reg <= !hit_0 && hit_1;
              end else begin
                state_reg <= ST_IDLE; // line stays released: nack
              end
            end else begin
              sda_oe_reg <= 1'b1;
              state_reg <= ST_WACK;
              wr_first_reg <= 1'b0;
              ptr_reg <= wr_first_reg ? shift_reg : ptr_reg + 8'h01;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            if (shift_reg[0]) begin
              // read: first data bit goes out on this fall
              sda_oe_reg <= !rd_data[7];
              shift_reg <= {rd_data[6:0], 1'b0};
              bit_cnt_reg <= 4'h1;
              state_reg <= ST_RDAT;
            end else begin
              sda_oe_reg <= 1'b0;
              state_reg <= ST_WDAT;
            end
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            sda_oe_reg <= 1'b0;
            state_reg <= ST_WDAT;
          end
        end
        ST_RDAT: begin
          if (scl_fall) begin
            if (bit_cnt_reg == BITS_PER_BYTE) begin
              sda_oe_reg <= 1'b0; // release for the host's ack
              ptr_reg <= ptr_reg + 8'h01;
              state_reg <= ST_RACK;
            end else begin
              sda_oe_reg <= !shift_reg[7];
              shift_reg <= {shift_reg[6:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise && sda_s) begin
            state_reg <= ST_IDLE; // host nack: wait for its stop
          end else if (scl_fall) begin
            sda_oe_reg <= !rd_data[7]; // ack: next byte, pointer advanced
            shift_reg <= {rd_data[6:0], 1'b0};
            bit_cnt_reg <= 4'h1;
            state_reg <= ST_RDAT;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // data pin only ever pulls low
  always_ff @(posedge CLK) begin
    sda_out_reg <= 1'b0;
  end

  assign SDA_OE = sda_oe_reg;
  assign SDA_OUT = sda_out_reg;

  // levels handed to the link domain
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      rst_flag_reg <= 1'b1;
      fast_cc_reg <= 2'h0;
    end else begin
      rst_flag_reg <= rst_any;
      for (int i = 0; i < 2; i++) begin
        fast_cc_reg[i] <= cfg_reg[i][RATE_LSB +: RATE_W] != RATE_SLOW;
      end
    end
  end

  // link domain: reset, rate and gpio pass two flops each
  logic [7:0] lk_s1_reg;
  logic [7:0] lk_s2_reg;
  logic lrst;
  logic [1:0] lfast;
  logic [3:0] lgpio;

  always_ff @(posedge LINK_CLK) begin
    lk_s1_reg <= {rst_flag_reg, fast_cc_reg, GPIO_IN, 1'b0};
    lk_s2_reg <= lk_s1_reg;
  end

  assign lrst = lk_s2_reg[7];
  assign lfast = lk_s2_reg[6:5];
  assign lgpio = lk_s2_reg[4:1];

  // one back-channel frame sender per receive port
  for (genvar p = 0; p < 2; p++) begin : g_bc
    logic [4:0] div_cnt_reg; // slow-rate bit divider
    logic [3:0] bit_idx_reg; // position in the frame
    logic [FRAME_W-1:0] frame_reg;
    logic tx_reg;
    logic tick;

    // fast rate sends a bit every link cycle, slow one in SLOW_DIV
    assign tick = lfast[p] || (div_cnt_reg == 5'(SLOW_DIV - 1));

    always_ff @(posedge LINK_CLK) begin
      if (lrst) begin
        div_cnt_reg <= 5'h00;
        bit_idx_reg <= 4'h0;
        frame_reg <= '0;
        tx_reg <= 1'b1;
      end else begin
        div_cnt_reg <= tick ? 5'h00 : div_cnt_reg + 5'h01;
        if (tick) begin
          if (bit_idx_reg == 4'h0) begin
            // header, capabilities, then gpio levels
            tx_reg <= FRAME_HDR[3];
            frame_reg <= {FRAME_HDR[2:0], CAPS_DEF, lgpio, 1'b0};
            bit_idx_reg <= 4'(FRAME_W - 1);
          end else begin
            tx_reg <= frame_reg[FRAME_W-1];
            frame_reg <= {frame_reg[FRAME_W-2:0], 1'b0};
            bit_idx_reg <= bit_idx_reg - 4'h1;
          end
        end
      end
    end

    assign BACKCHANNEL_TX[p] = tx_reg;

    property p_slow_tick;
      @(posedge LINK_CLK) disable iff (lrst)
      (!lfast[p] && div_cnt_reg == 5'h00 && $past(div_cnt_reg) == 5'h00)
        |-> ##1 (div_cnt_reg == 5'h01) ##1 (div_cnt_reg == 5'h02);
    endproperty
    a_slow_tick: assert property (p_slow_tick) else $error("slow divider off");
  end

  // checks on the target side
  property p_strap_wait;
    @(posedge CLK) disable iff (!RSTN)
    $rose(addr_valid_reg) |-> $past(wait_cnt_reg) == WAIT_W'(STRAP_WAIT_CYC - 1);
  endproperty
  a_strap_wait: assert property (p_strap_wait) else $error("strap taken early");

  property p_strap_addr;
    @(posedge CLK) disable iff (!RSTN)
    $rose(addr_valid_reg) |-> prim_reg == {strap_addr($past(strap_s)), 1'b0};
  endproperty
  a_strap_addr: assert property (p_strap_addr) else $error("strap decode wrong");

  property p_rate_default;
    @(posedge CLK) disable iff (!RSTN)
    $rose(addr_valid_reg) |->
      cfg_reg[1][RATE_LSB +: RATE_W] == ($past(mode_s) ? RATE_FAST : RATE_SLOW);
  endproperty
  a_rate_default: assert property (p_rate_default) else $error("rate default wrong");

  property p_addr_nack;
    @(posedge CLK) disable iff (!RSTN)
    (addr_valid_reg && !start_det && !stop_det && state_reg == ST_ADDR && scl_fall
      && bit_cnt_reg == BITS_PER_BYTE && !any_hit) |=> (state_reg == ST_IDLE && !sda_oe_reg);
  endproperty
  a_addr_nack: assert property (p_addr_nack) else $error("mismatch not released");

  property p_addr_ack;
    @(posedge CLK) disable iff (!RSTN)
    state_reg == ST_AACK |-> sda_oe_reg;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address not acked");

  property p_data_ack;
    @(posedge CLK) disable iff (!RSTN)
    $rose(state_reg == ST_WACK) |-> sda_oe_reg && $past(state_reg) == ST_WDAT;
  endproperty
  a_data_ack: assert property (p_data_ack) else $error("data byte not acked");

  property p_stop;
    @(posedge CLK) disable iff (!RSTN)
    (stop_det && addr_valid_reg && pwr_on_s) |=> state_reg == ST_IDLE && !sda_oe_reg;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not end transfer");

  property p_low_only;
    @(posedge CLK) disable iff (!RSTN)
    // the line is pulled only for an ack or a zero read bit
    SDA_OE |-> !SDA_OUT && (state_reg inside {ST_AACK, ST_WACK, ST_RDAT});
  endproperty
  a_low_only: assert property (p_low_only) else $error("sda driven high");

  property p_direct_page;
    @(posedge CLK) disable iff (!RSTN)
    ($rose(state_reg == ST_AACK) && direct_reg)
      |-> port_addr_reg[page_reg][7:1] == $past(shift_reg[7:1]);
  endproperty
  a_direct_page: assert property (p_direct_page) else $error("direct page wrong");

  c_write_ack: cover property (@(posedge CLK) state_reg == ST_WACK);
  c_read_byte: cover property (@(posedge CLK) state_reg == ST_RACK);
  c_direct: cover property (@(posedge CLK) state_reg == ST_AACK && direct_reg);
  c_nack: cover property (@(posedge CLK) state_reg == ST_ADDR ##1 state_reg == ST_IDLE);
endmodule // i2c_hub_target

//--- tb/i2c_host_model.sv
`timescale 1ns/1ns
// host controller on the local bus, open-drain: it only pulls low or releases
module i2c_host_model (
  // pacing clock
  input wire logic CLK,
  // resolved data line
  input wire logic SDA_BUS,
  // line releases, high = let pull-up win
  output logic SCL_REL,
  output logic SDA_REL
);
  localparam int QTR = 25; // quarter bit: 1 MHz bus clock

  // idle bus, both lines released
  initial begin
    SCL_REL = 1'b1;
    SDA_REL = 1'b1;
  end

  // one quarter bit, always stepped on the falling edge
  task automatic q();
    repeat (QTR) @(negedge CLK);
  endtask

  // start or repeated start opens each transfer
  task automatic start();
    SDA_REL = 1'b1;
    q();
    SCL_REL = 1'b1;
    q();
    SDA_REL = 1'b0;
    q();
    SCL_REL = 1'b0;
    q();
  endtask

  // stop: data rises while the clock is high
  task automatic stop();
    SDA_REL = 1'b0;
    q();
    SCL_REL = 1'b1;
    q();
    SDA_REL = 1'b1;
    q();
  endtask

  // eight bits msb first plus the ninth from ack_in; sda only moves with scl low
  task automatic byte_io(input logic [7:0] d, input logic ack_in,
                         output logic [7:0] r, output logic ack);
    logic [8:0] s;
    logic [8:0] o;
    s = {d, ack_in};
    for (int i = 8; i >= 0; i--) begin
      SDA_REL = s[i];
      q();
      SCL_REL = 1'b1;
      q();
      o[i] = SDA_BUS;
      q();
      SCL_REL = 1'b0;
      q();
    end
    r = o[8:1];
    ack = ~o[0];
  endtask

  // local register write only, never a remote access
  task automatic wr(input logic [6:0] a, input logic [7:0] ofs, input logic [7:0] d,
                    output logic [2:0] acks);
    logic [7:0] r;
    start();
    byte_io({a, 1'b0}, 1'b1, r, acks[2]);
    byte_io(ofs, 1'b1, r, acks[1]);
    byte_io(d, 1'b1, r, acks[0]);
    stop();
  endtask

  // pointer write, repeated start, one byte nacked then stop
  task automatic rd(input logic [6:0] a, input logic [7:0] ofs, output logic [7:0] d,
                    output logic [2:0] acks);
    logic [7:0] r;
    logic n;
    start();
    byte_io({a, 1'b0}, 1'b1, r, acks[2]);
    byte_io(ofs, 1'b1, r, acks[1]);
    start();
    byte_io({a, 1'b1}, 1'b1, r, acks[0]);
    byte_io(8'hff, 1'b1, d, n);
    stop();
  endtask

  // two-byte read: first byte acked so a second byte is sent, last nacked
  task automatic rd2(input logic [6:0] a, input logic [7:0] ofs, output logic [15:0] d,
                     output logic [2:0] acks);
    logic [7:0] r;
    logic n;
    start();
    byte_io({a, 1'b0}, 1'b1, r, acks[2]);
    byte_io(ofs, 1'b1, r, acks[1]);
    start();
    byte_io({a, 1'b1}, 1'b1, r, acks[0]);
    byte_io(8'hff, 1'b0, d[15:8], n);
    byte_io(8'hff, 1'b1, d[7:0], n);
    stop();
  endtask
endmodule // i2c_host_model

//--- tb/testbench.sv
`timescale 1ns/1ns
// local register traffic against the hub target, plus back channel frames
module testbench;
  import i2c_hub_pkg::*;
  localparam int WAIT_CYC = 400; // shortened strap settle delay
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rstn = 1'b0;
  logic pd_rel = 1'b0;
  logic [2:0] strap = 3'h0;
  logic mode = 1'b0;
  logic [1:0] lock = 2'b10;
  logic [3:0] gpio = 4'h5;
  logic scl_rel;
  logic sda_rel;
  logic sda_oe;
  logic sda_out;
  logic [1:0] bc_tx;
  logic sda_bus;
  logic [11:0] sh0 = 12'h000;
  i2c_pins_t pins;
  int failures = 0;
  int n_tests = 0;

  // pull-up wins unless someone pulls low
  assign sda_bus = sda_rel & ~sda_oe;
  assign pins.scl = scl_rel;
  assign pins.sda = sda_bus;

  // system clock 100 MHz
  always #5 clk = ~clk;
  // link clock 15 ns, phase offset from clk
  initial begin
    #3;
    forever begin
      #7 link_clk = 1'b1;
      #8 link_clk = 1'b0;
    end
  end

  i2c_hub_target #(.STRAP_WAIT_CYC(WAIT_CYC)) u_dut (
    .CLK(clk), .RSTN(rstn), .POWER_DOWN_RELEASE_PIN(pd_rel),
    .ADDRESS_STRAP_PIN(strap), .MODE_STRAP_PIN(mode), .PORT_LOCK(lock),
    .I2C_IN(pins), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .LINK_CLK(link_clk), .GPIO_IN(gpio), .BACKCHANNEL_TX(bc_tx));

  i2c_host_model u_host (.CLK(clk), .SDA_BUS(sda_bus), .SCL_REL(scl_rel), .SDA_REL(sda_rel));

  // compare and count
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // read with all three acks expected
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] ofs,
                        input logic [7:0] exp, input string what);
    logic [7:0] d;
    logic [2:0] k;
    u_host.rd(a, ofs, d, k);
    check(d, exp, what);
    check({5'h0, k}, 8'h07, what);
  endtask

  // write with an expected ack pattern: address, pointer, data
  task automatic wr_chk(input logic [6:0] a, input logic [7:0] ofs, input logic [7:0] d,
                        input logic [2:0] exp_k);
    logic [2:0] k;
    u_host.wr(a, ofs, d, k);
    check({5'h0, k}, {5'h0, exp_k}, "write acks");
  endtask

  // shift lane 0 on the link clock for frame matching
  always @(posedge link_clk) begin
    sh0 <= {sh0[10:0], bc_tx[0]};
  end

  // lane 0 fast: whole frames seen; lane 1 slow: few transitions
  task automatic bc_check();
    int hits;
    int flips;
    logic prev;
    hits = 0;
    flips = 0;
    prev = bc_tx[1];
    repeat (60) begin
      @(posedge link_clk);
      #1;
      if (sh0 === {4'ha, 4'h3, gpio}) hits++;
      if (bc_tx[1] !== prev) flips++;
      prev = bc_tx[1];
    end
    check({7'h0, hits > 3}, 8'h01, "fast frames");
    check({7'h0, flips >= 1 && flips <= 4}, 8'h01, "slow lane rate");
  endtask

  // the target only ever pulls sda low, scl is never an output
  always @(negedge clk) begin
    if (sda_oe === 1'b1) check({7'h0, sda_out}, 8'h00, "sda driven high");
  end

  // hang guard
  initial begin
    repeat (98000) @(posedge clk);
    failures++;
    $display("[ERR] %0t run timed out", $time);
    complete_run();
  end

  // main sequence
  initial begin
    logic [6:0] pa;
    logic [2:0] ak;
    logic [15:0] d2;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    // every strap level through a power-down cycle; mode follows level lsb
    for (int l = 0; l < 8; l++) begin
      pa = (l == 7) ? 7'h3d : 7'(48 + 2 * l);
      strap = 3'(l);
      mode = strap[0];
      pd_rel = 1'b0;
      repeat (4) @(negedge clk);
      pd_rel = 1'b1;
      if (l == 0) begin
        // too early, strap not taken: whole transfer ignored
        u_host.wr(pa, 8'h4c, 8'h12, ak);
        check({5'h0, ak}, 8'h00, "early access acked");
      end else begin
        repeat (WAIT_CYC + 100) @(negedge clk);
      end
      rd_chk(pa, 8'h00, {pa, 1'b0}, "strap address");
      if (l >= 6) rd_chk(pa, 8'h58, mode ? 8'h06 : 8'h00, "mode rate");
    end
    rd_chk(7'h3d, 8'h4c, 8'h01, "port select");
    rd_chk(7'h3d, 8'hf8, 8'h00, "port0 addr reset");
    wr_chk(7'h77, 8'h58, 8'h00, 3'b000);
    wr_chk(7'h3d, 8'hf8, 8'ha0, 3'b111);
    wr_chk(7'h3d, 8'hf9, 8'ha2, 3'b111);
    wr_chk(7'h51, 8'h58, 8'h00, 3'b111);
    rd_chk(7'h50, 8'h58, 8'h06, "port0 rate");
    rd_chk(7'h51, 8'h58, 8'h00, "port1 rate");
    rd_chk(7'h51, 8'h00, 8'h7a, "shared via port1");
    // burst read across both direct address registers, pointer steps on the fall after each byte's eighth bit
    u_host.rd2(7'h50, 8'hf8, d2, ak);
    check(d2[15:8], 8'ha0, "burst byte 0");
    check(d2[7:0], 8'ha2, "burst byte 1");
    check({5'h0, ak}, 8'h07, "burst acks");
    wr_chk(7'h3d, 8'h4c, 8'h12, 3'b111);
    rd_chk(7'h3d, 8'h58, 8'h00, "paged rate");
    rd_chk(7'h3d, 8'h4d, 8'h01, "paged lock");
    // gpio levels must show up in the frames
    for (int g = 0; g < 2; g++) begin
      gpio = (g == 0) ? 4'h5 : 4'ha;
      repeat (20) @(negedge clk);
      bc_check();
    end
    complete_run();
  end
endmodule // testbench
